// File: logic/tick_timer_pkg.sv
// Constants and types shared by the tick timer and its divider
package tick_timer_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register bus geometry
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;

	// Register offsets; the top address bit selects a bank pair and is
	// ignored, the irq control register also ignores bit 7
	localparam logic [7:0] TICK_COUNT_OFS = 8'h01;
	localparam logic [7:0] TIMER_OPTION_OFS = 8'h81;
	localparam logic [6:0] IRQ_CONTROL_OFS = 7'h0b;

	////////////////////////////////////////////////////////////////////////
	// Interrupt control register fields
	localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
	localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
	localparam int TICK_OVERFLOW_ENABLE_BIT = 5;
	localparam int EXT_PIN_IRQ_ENABLE_BIT = 4;
	localparam int PORT_CHANGE_ENABLE_BIT = 3;
	localparam int TICK_OVERFLOW_FLAG_BIT = 2;
	localparam int EXT_PIN_IRQ_FLAG_BIT = 1;
	localparam int PORT_CHANGE_FLAG_BIT = 0;

	// Option register fields
	localparam int COUNT_SOURCE_SELECT_BIT = 5;
	localparam int COUNT_EDGE_SELECT_BIT = 4;
	localparam int DIVIDER_ASSIGNMENT_BIT = 3;
	localparam int DIVIDER_RATIO_LSB = 0;
	localparam int DIVIDER_RATIO_W = 3;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] TICK_COUNT_RST = 8'h00;
	localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;
	localparam logic [7:0] TIMER_OPTION_RST = 8'hff;
	localparam logic [7:0] READ_IDLE = 8'h00;
	localparam logic [7:0] TICK_ALL_ONES = 8'hff;

	// Timing: four oscillator phases make one instruction cycle
	localparam int PHASES_PER_INSTR = 4;
	localparam int DIVIDER_W = 8;

	// Instruction-cycle phases, Gray coded
	typedef enum logic [1:0] {
		PH_ONE = 2'h0,
		PH_TWO = 2'h1,
		PH_THREE = 2'h3,
		PH_FOUR = 2'h2
	} phase_t;

endpackage

// File: logic/tick_divider.sv
// Shared divider count, cleared on request, stepped by single pulses
`timescale 1ns/1ps
module tick_divider
	import tick_timer_pkg::*;
#(
	parameter int WIDTH = DIVIDER_W
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Control
	input wire logic step_i,
	input wire logic clear_i,
	// Count
	output logic [WIDTH-1:0] count_o
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
	} div_state_t;

	div_state_t st_r;
	div_state_t st_nxt;

	////////////////////////////////////////////////////////////////////////
	// Clear wins over a step in the same cycle
	always_comb
	begin
		st_nxt = st_r;
		if (clear_i)
		begin
			st_nxt.count = '0;
		end
		else if (step_i)
		begin
			st_nxt.count = st_r.count + WIDTH'(1);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign count_o = st_r.count;

endmodule

// File: logic/tick_timer_prescaler_irq.sv
// Eight-bit tick timer with shared divider and interrupt control
//
// What this block does
// R1: Flags set on events, regardless of enables.
// R2: Bit 7 global enable gates all interrupts.
// R3: Bit 6 gates the peripheral interrupt group.
// R4: Enable and flag for three sources.
// R5: Software clears flag before enabling its source.
// R6: Interrupt control mirrored in all four banks.
// R7: Option bit 5 selects pin or instruction clock.
// R8: Option bit 4 selects falling or rising edge.
// R9: Option bit 3 gives divider to watchdog.
// R10: Ratio field divides timer 2^(n+1), watchdog 2^n.
// R11: One divider; the other side runs undivided.
// R12: Tick count write clears divider when timer-owned.
// R13: Watchdog clear clears divider when watchdog-owned.
// R14: Divider count has no register address.
// R15: Undivided source passes straight to the timer.
// R16: Source sampled on phases two and four.
// R17: Pin level held at least two oscillator periods.
// R18: Timer wraps to zero, setting overflow flag.
// R19: Hardware set beats a simultaneous software clear.
// R20: Request is enables and flags combined.
`timescale 1ns/1ps
module tick_timer_prescaler_irq
	import tick_timer_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	// Count pin, asynchronous
	input wire logic ext_count_pin_i,
	// Interrupt sources and peripheral group
	input wire logic ext_pin_event_i,
	input wire logic port_change_event_i,
	input wire logic peripheral_irq_i,
	// Watchdog side
	input wire logic watchdog_base_tick_i,
	input wire logic watchdog_clear_instr_i,
	output logic watchdog_tick_o,
	// Interrupt request
	output logic irq_o
);

	typedef struct packed {
		phase_t phase;
		logic pin_meta;
		logic pin_sync;
		logic src_prev;
		logic sample;
		logic [7:0] tick;
		logic [7:0] icon;
		logic [7:0] opt;
		logic [7:0] rdata;
		logic wdt_tick;
		logic irq;
	} state_t;

	localparam state_t ST_RESET = '{
		phase: PH_ONE,
		pin_meta: 1'b0,
		pin_sync: 1'b0,
		// Edge detectors start high: no false count after reset
		src_prev: 1'b1,
		sample: 1'b1,
		tick: TICK_COUNT_RST,
		icon: IRQ_CONTROL_RST,
		opt: TIMER_OPTION_RST,
		rdata: READ_IDLE,
		wdt_tick: 1'b0,
		irq: 1'b0
	};

	state_t st_r;
	state_t st_nxt;

	logic [DIVIDER_W-1:0] div_count;
	logic div_step;
	logic div_clear;
	logic src_sel;
	logic edge_sel;
	logic div_to_wdt;
	logic [DIVIDER_RATIO_W-1:0] ratio;
	logic instr_level;
	logic ext_level;
	logic src_level;
	logic timer_level;
	logic sample_now;
	logic tick_inc;
	logic tick_ovf;
	logic tick_wr;
	logic icon_wr;
	logic opt_wr;
	logic [7:0] wdt_mask;
	logic [7:0] icon_base;
	logic req_any;

	////////////////////////////////////////////////////////////////////////
	// Shared divider
	tick_divider #(
		.WIDTH(DIVIDER_W)
	) u_divider (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.step_i(div_step),
		.clear_i(div_clear),
		.count_o(div_count)
	);

	////////////////////////////////////////////////////////////////////////
	// Decode and datapath
	always_comb
	begin
		st_nxt = st_r;
		src_sel = st_r.opt[COUNT_SOURCE_SELECT_BIT];
		edge_sel = st_r.opt[COUNT_EDGE_SELECT_BIT];
		div_to_wdt = st_r.opt[DIVIDER_ASSIGNMENT_BIT];
		ratio = st_r.opt[DIVIDER_RATIO_LSB +: DIVIDER_RATIO_W];

		tick_wr = reg_write_i && (reg_addr_i[7:0] == TICK_COUNT_OFS);
		icon_wr = reg_write_i && (reg_addr_i[6:0] == IRQ_CONTROL_OFS); // [R6]
		opt_wr = reg_write_i && (reg_addr_i[7:0] == TIMER_OPTION_OFS);

		// Phase sequencer: one instruction cycle per four clocks
		case (st_r.phase)
			PH_ONE: st_nxt.phase = PH_TWO;
			PH_TWO: st_nxt.phase = PH_THREE;
			PH_THREE: st_nxt.phase = PH_FOUR;
			PH_FOUR: st_nxt.phase = PH_ONE;
			default: st_nxt.phase = PH_ONE;
		endcase

		// Pin synchroniser
		st_nxt.pin_meta = ext_count_pin_i;
		st_nxt.pin_sync = st_r.pin_meta;

		// Instruction clock rises into phase three
		instr_level = (st_r.phase == PH_THREE) || (st_r.phase == PH_FOUR);
		ext_level = st_r.pin_sync ^ edge_sel; // [R8]
		src_level = src_sel ? ext_level : instr_level; // [R7]
		st_nxt.src_prev = src_level;

		// Divider input and clear
		div_step = div_to_wdt ? watchdog_base_tick_i
			: (src_level & ~st_r.src_prev); // [R9] [R11]
		div_clear = (tick_wr & ~div_to_wdt) // [R12]
			| (watchdog_clear_instr_i & div_to_wdt); // [R13]

		// Bit n of the count rises once per 2^(n+1) steps
		timer_level = div_to_wdt ? src_level : div_count[ratio]; // [R10] [R15]

		sample_now = (st_r.phase == PH_TWO) || (st_r.phase == PH_FOUR);
		tick_inc = 1'b0;
		if (sample_now) // [R16]
		begin
			st_nxt.sample = timer_level;
			tick_inc = timer_level & ~st_r.sample;
		end

		// Watchdog tick every 2^n base ticks when it owns the divider
		wdt_mask = 8'(({1'b0, 8'hff} << ratio) ^ {1'b0, 8'hff});
		if (div_to_wdt)
		begin
			st_nxt.wdt_tick = watchdog_base_tick_i
				&& ((div_count & wdt_mask) == wdt_mask); // [R10]
		end
		else
		begin
			st_nxt.wdt_tick = watchdog_base_tick_i; // [R11]
		end

		// Tick count; a write takes the place of the increment
		tick_ovf = 1'b0;
		if (tick_wr)
		begin
			st_nxt.tick = reg_wdata_i;
		end
		else if (tick_inc)
		begin
			st_nxt.tick = st_r.tick + 8'h01; // [R18]
			tick_ovf = (st_r.tick == TICK_ALL_ONES); // [R18]
		end

		// Interrupt control: hardware sets win over the write
		icon_base = icon_wr ? reg_wdata_i : st_r.icon; // [R4]
		st_nxt.icon = icon_base;
		st_nxt.icon[TICK_OVERFLOW_FLAG_BIT] =
			icon_base[TICK_OVERFLOW_FLAG_BIT] | tick_ovf; // [R1] [R19]
		st_nxt.icon[EXT_PIN_IRQ_FLAG_BIT] =
			icon_base[EXT_PIN_IRQ_FLAG_BIT] | ext_pin_event_i; // [R1] [R19]
		st_nxt.icon[PORT_CHANGE_FLAG_BIT] =
			icon_base[PORT_CHANGE_FLAG_BIT]
			| port_change_event_i; // [R1] [R19]

		if (opt_wr)
		begin
			st_nxt.opt = reg_wdata_i;
		end

		// Read data for one cycle only; the divider has no address
		st_nxt.rdata = READ_IDLE;
		if (reg_read_i)
		begin
			if (reg_addr_i[6:0] == IRQ_CONTROL_OFS) // [R6]
			begin
				st_nxt.rdata = st_r.icon;
			end
			else if (reg_addr_i[7:0] == TICK_COUNT_OFS)
			begin
				st_nxt.rdata = st_r.tick;
			end
			else if (reg_addr_i[7:0] == TIMER_OPTION_OFS)
			begin
				st_nxt.rdata = st_r.opt;
			end
			else
			begin
				st_nxt.rdata = READ_IDLE; // [R14]
			end
		end

		// Interrupt request
		req_any = (st_r.icon[TICK_OVERFLOW_ENABLE_BIT]
				& st_r.icon[TICK_OVERFLOW_FLAG_BIT])
			| (st_r.icon[EXT_PIN_IRQ_ENABLE_BIT]
				& st_r.icon[EXT_PIN_IRQ_FLAG_BIT])
			| (st_r.icon[PORT_CHANGE_ENABLE_BIT]
				& st_r.icon[PORT_CHANGE_FLAG_BIT])
			| (st_r.icon[PERIPHERAL_GROUP_ENABLE_BIT]
				& peripheral_irq_i); // [R3] [R20]
		st_nxt.irq = st_r.icon[GLOBAL_IRQ_ENABLE_BIT] & req_any; // [R2] [R20]
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			st_r <= ST_RESET;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata_o = st_r.rdata;
	assign watchdog_tick_o = st_r.wdt_tick;
	assign irq_o = st_r.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_flag_on_overflow: // [R1] [R18]
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(tick_inc && !tick_wr && st_r.tick == 8'hff)
		|=> (st_r.tick == 8'h00) && st_r.icon[TICK_OVERFLOW_FLAG_BIT])
	else $error("overflow did not wrap and set its flag");

	a_set_beats_clear: // [R19]
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(icon_wr && ext_pin_event_i)
		|=> st_r.icon[EXT_PIN_IRQ_FLAG_BIT])
	else $error("pin event lost to a software clear");

	a_global_gate: // [R2]
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!st_r.icon[GLOBAL_IRQ_ENABLE_BIT] |=> !irq_o)
	else $error("request raised with global enable clear");

	a_peripheral_gate: // [R3]
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_r.icon[7:6] == 2'b11 && peripheral_irq_i) |=> irq_o)
	else $error("enabled peripheral request not raised");

	a_mirror_read: // [R6]
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(reg_read_i && reg_addr_i[6:0] == 7'h0b)
		|=> reg_rdata_o == $past(st_r.icon))
	else $error("mirrored control read returned wrong data");

	a_write_clears_div: // [R12]
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(tick_wr && !div_to_wdt) |=> div_count == 8'h00)
	else $error("tick write did not clear divider");

	a_wdt_clear_div: // [R13]
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(watchdog_clear_instr_i && div_to_wdt) |=> div_count == 8'h00)
	else $error("watchdog clear did not clear divider");

	a_wdt_undivided: // [R11]
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(!div_to_wdt && watchdog_base_tick_i) |=> watchdog_tick_o)
	else $error("watchdog tick divided while timer owns divider");

	a_count_on_phase: // [R16]
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_r.tick != st_nxt.tick && !tick_wr)
		|-> (st_r.phase == PH_TWO || st_r.phase == PH_FOUR))
	else $error("tick moved outside a sampling phase");

	a_internal_rate: // [R7] [R15]
	assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_r.opt[5:3] == 3'b001 && st_r.phase == PH_FOUR
			&& !reg_write_i && $past(st_r.opt[5:3]) == 3'b001
			&& $past(st_r.opt[5:3], 2) == 3'b001
			&& $past(st_r.phase) == PH_THREE
			&& $past(reg_write_i) == 1'b0)
		|-> tick_inc)
	else $error("undivided internal clock missed an increment");

endmodule

// File: verif/tb.sv
// Self-checking bench for the tick timer with shared divider
`timescale 1ns/1ps
module tb;
	import tick_timer_pkg::*;

`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	miscompares++; $display("[ERR] %s expected %h seen %h", n, e, g); end end

	typedef struct {logic [7:0] opt; int clks; logic [7:0] diff;} row_t;

	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [ADDR_W-1:0] reg_addr_i = '0;
	logic [DATA_W-1:0] reg_wdata_i = '0;
	logic reg_write_i = 1'b0;
	logic reg_read_i = 1'b0;
	logic [DATA_W-1:0] reg_rdata_o;
	logic ext_count_pin_i = 1'b0;
	logic ext_pin_event_i = 1'b0;
	logic port_change_event_i = 1'b0;
	logic peripheral_irq_i = 1'b0;
	logic watchdog_base_tick_i = 1'b0;
	logic watchdog_clear_instr_i = 1'b0;
	logic watchdog_tick_o;
	logic irq_o;
	int miscompares = 0;
	int checks_done = 0;
	int wd_cnt = 0;
	int base;
	logic [7:0] v;
	logic [7:0] w;
	row_t rows[5] = '{'{8'h08, 40, 8'h0a}, '{8'h00, 80, 8'h0a},
		'{8'h02, 320, 8'h0a}, '{8'h07, 2048, 8'h02}, '{8'h28, 40, 8'h00}};

	tick_timer_prescaler_irq dut_u (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_write_i(reg_write_i),
		.reg_read_i(reg_read_i),
		.reg_rdata_o(reg_rdata_o),
		.ext_count_pin_i(ext_count_pin_i),
		.ext_pin_event_i(ext_pin_event_i),
		.port_change_event_i(port_change_event_i),
		.peripheral_irq_i(peripheral_irq_i),
		.watchdog_base_tick_i(watchdog_base_tick_i),
		.watchdog_clear_instr_i(watchdog_clear_instr_i),
		.watchdog_tick_o(watchdog_tick_o),
		.irq_o(irq_o)
	);

	always #25 clk_i = ~clk_i;

	always @(posedge clk_i)
		if (watchdog_tick_o === 1'b1)
			wd_cnt++;

	////////////////////////////////////////////////////////////////////////
	task automatic tk(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge clk_i);
		reg_write_i <= 1'b0;
	endtask

	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge clk_i);
		reg_read_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask

	// One-cycle event pulse: 0 pin, 1 port, 2 base tick, 3 clear
	task automatic evt(input int k);
		@(posedge clk_i);
		ext_pin_event_i <= (k == 0);
		port_change_event_i <= (k == 1);
		watchdog_base_tick_i <= (k == 2);
		watchdog_clear_instr_i <= (k == 3);
		@(posedge clk_i);
		ext_pin_event_i <= 1'b0;
		port_change_event_i <= 1'b0;
		watchdog_base_tick_i <= 1'b0;
		watchdog_clear_instr_i <= 1'b0;
	endtask

	task automatic test_done;
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		#3_000_000;
		miscompares++;
		test_done();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		tk(10);
		sys_rst_i <= 1'b0;
		// Count rate per source, ratio and owner
		foreach (rows[i])
		begin
			wr(9'h081, rows[i].opt);
			tk(8);
			rd(9'h001, v);
			tk(rows[i].clks - 2);
			rd(9'h101, w);
			`CHK("tick rate", rows[i].diff, w - v)
		end
		// Second reset in mid-run
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		tk(2);
		sys_rst_i <= 1'b0;
		rd(9'h101, v);
		`CHK("tick reset", 8'h00, v)
		rd(9'h181, v);
		`CHK("option reset", 8'hff, v)
		rd(9'h18b, v);
		`CHK("irq reset", 8'h00, v)
		wr(9'h002, 8'h5a);
		rd(9'h002, v);
		`CHK("unmapped", 8'h00, v)
		rd(9'h081, v);
		`CHK("option kept", 8'hff, v)
		rd(9'h001, v);
		`CHK("tick idle", 8'h00, v)
		// Mirrors of the irq control register
		wr(9'h08b, 8'h38);
		foreach (rows[i])
		begin
			if (i < 4)
			begin
				rd({i[1:0], 7'h0b}, v);
				`CHK("irq mirror", 8'h38, v)
			end
		end
		wr(9'h00b, 8'h00);
		// Flags set with all enables clear
		evt(0);
		rd(9'h00b, v);
		`CHK("pin flag", 8'h02, v)
		evt(1);
		rd(9'h00b, v);
		`CHK("port flag", 8'h03, v)
		`CHK("irq masked", 1'b0, irq_o)
		@(posedge clk_i);
		reg_addr_i <= 9'h00b;
		reg_wdata_i <= 8'h00;
		reg_write_i <= 1'b1;
		ext_pin_event_i <= 1'b1;
		@(posedge clk_i);
		reg_write_i <= 1'b0;
		ext_pin_event_i <= 1'b0;
		rd(9'h00b, v);
		`CHK("set beats clear", 8'h02, v)
		wr(9'h00b, 8'h92);
		tk(3);
		`CHK("irq pin", 1'b1, irq_o)
		wr(9'h00b, 8'h12);
		tk(3);
		`CHK("irq global off", 1'b0, irq_o)
		wr(9'h00b, 8'h00);
		peripheral_irq_i <= 1'b1;
		wr(9'h00b, 8'h80);
		tk(3);
		`CHK("irq group off", 1'b0, irq_o)
		wr(9'h00b, 8'hc0);
		tk(3);
		`CHK("irq group on", 1'b1, irq_o)
		peripheral_irq_i <= 1'b0;
		wr(9'h00b, 8'h00);
		// Overflow from all ones
		wr(9'h081, 8'h08);
		tk(8);
		wr(9'h00b, 8'h00);
		wr(9'h001, 8'hff);
		v = 8'h00;
		for (int i = 0; i < 10 && v !== 8'h04; i++)
			rd(9'h00b, v);
		`CHK("ovf flag", 8'h04, v)
		rd(9'h001, w);
		`CHK("tick wrapped", 1'b1, w < 8'h03)
		wr(9'h00b, 8'ha4);
		tk(3);
		`CHK("irq ovf", 1'b1, irq_o)
		wr(9'h00b, 8'h00);
		// Tick write clears the divider
		wr(9'h081, 8'h07);
		tk(8);
		wr(9'h001, 8'h00);
		tk(400);
		rd(9'h001, v);
		`CHK("div cleared", 8'h00, v)
		tk(200);
		rd(9'h001, v);
		`CHK("div first step", 8'h01, v)
		// Pin edges, rising then falling select
		for (int i = 0; i < 2; i++)
		begin
			wr(9'h081, i ? 8'h38 : 8'h28);
			tk(20);
			wr(9'h001, 8'h00);
			ext_count_pin_i <= 1'b1;
			tk(20);
			rd(9'h001, v);
			`CHK("pin high", i ? 8'h00 : 8'h01, v)
			ext_count_pin_i <= 1'b0;
			tk(20);
			rd(9'h001, v);
			`CHK("pin low", 8'h01, v)
		end
		// Watchdog side of the divider
		wr(9'h081, 8'h0a);
		evt(2);
		evt(2);
		evt(3);
		base = wd_cnt;
		repeat (7) evt(2);
		tk(3);
		`CHK("wdt divided", 1, wd_cnt - base)
		wr(9'h081, 8'h00);
		base = wd_cnt;
		repeat (3) evt(2);
		tk(3);
		`CHK("wdt undivided", 3, wd_cnt - base)
		test_done();
	end
endmodule
